// [rtl/io_port_pkg.sv]
/*
 six-bit io port: register offsets, field widths, reset values and carrier structs.
 assumes a 16-bit low-address register port and one 25 MHz clock.
*/
// Operation
// - six two-way pins 5..0; register bits 7 and 6 unimplemented
// - pins shareable with serial transmit, receive, clock and two interrupt inputs
// - pin function selection is identical in every operating mode
// - direction register write-only; reads return an undefined value
// - direction bit 1 makes pin output, 0 makes it input
// - reset and hardware standby clear direction bits to zero
// - software standby keeps direction and output latch values
// - serial interface idle: pins follow direction and output latch
// - output latch read/write; bits 5..0 drive output pins
// - reset and hardware standby clear output latch bits to zero
// - reserved latch bits read undetermined, writes ignored
// - addresses decoded on low 16 bits; reset values cover bits 5..0
// - readback gives latch bit for outputs, two-stage synchronised pin level for inputs
// - open-drain bit 1 disables high drive; 0 gives push-pull
// - open-drain bits cleared by reset and hardware standby, kept in software standby
package io_port_pkg;
    localparam int PORT_WIDTH = 6;
    localparam int REG_WIDTH = 8;
    localparam int ADDR_WIDTH = 16;
    localparam logic [15:0] PIN_DIRECTION_ADDR = 16'hFEB2;
    localparam logic [15:0] PIN_LEVEL_READBACK_ADDR = 16'hFF52;
    localparam logic [15:0] OUTPUT_LATCH_ADDR = 16'hFF62;
    localparam logic [15:0] OPEN_DRAIN_SELECT_ADDR = 16'hFF76;
    localparam logic [5:0] PIN_DIRECTION_RESET = 6'h00;
    localparam logic [5:0] OUTPUT_LATCH_RESET = 6'h00;
    localparam logic [5:0] OPEN_DRAIN_SELECT_RESET = 6'h00;
    // value shown for reserved bits and write-only reads
    localparam logic [1:0] RESERVED_READ = 2'h0;
    localparam logic [7:0] UNDEFINED_READ = 8'h00;
    // index of the two pins that double as interrupt inputs
    localparam int IRQ_A_PIN = 4;
    localparam int IRQ_B_PIN = 5;

    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    // per-pin control from a peripheral taking over pins
    typedef struct packed {
        logic [5:0] take;
        logic [5:0] oe;
        logic [5:0] out;
    } periph_ctl_type;

    // pin pad signals
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } pad_drive_type;
endpackage

// [rtl/io_pad_driver.sv]
/*
 per-pin output stage: chooses port or peripheral control and applies open drain.
 assumes purely combinational use inside the io port.
*/
`timescale 1ns/10ps
module io_pad_driver #(
    parameter int WIDTH = 6
) (
    input wire logic [WIDTH-1:0] i_dir,
    input wire logic [WIDTH-1:0] i_latch,
    input wire logic [WIDTH-1:0] i_odr,
    input wire logic [WIDTH-1:0] i_take,
    input wire logic [WIDTH-1:0] i_p_oe,
    input wire logic [WIDTH-1:0] i_p_out,
    output logic [WIDTH-1:0] o_out,
    output logic [WIDTH-1:0] o_oe
);
    logic [WIDTH-1:0] want_oe;
    logic [WIDTH-1:0] want_val;

    // peripheral wins where it has taken the pin
    assign want_oe = (i_take & i_p_oe) | (~i_take & i_dir);
    assign want_val = (i_take & i_p_out) | (~i_take & i_latch);

    // open drain only ever pulls low, so a high value releases the pin
    assign o_oe = want_oe & ~(i_odr & want_val);
    assign o_out = want_val & ~i_odr;
endmodule

// [rtl/io_port.sv]
/*
 six-bit general purpose io port with direction, output latch,
 pin readback and open-drain select registers.
 assumes a single-cycle register port, read data one cycle later;
 serial peripherals supply takeover controls from the same clock.
*/
`timescale 1ns/10ps
module io_port
    import io_port_pkg::*;
#(
    parameter int WIDTH = io_port_pkg::PORT_WIDTH
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hw_standby,
    input wire io_port_pkg::reg_req_type i_req,
    output logic [7:0] o_rdata,
    input wire io_port_pkg::periph_ctl_type i_periph,
    input wire logic [5:0] i_pin,
    output logic [5:0] o_pin_out,
    output logic [5:0] o_pin_oe,
    output logic [5:0] o_pin_level,
    output logic o_ext_interrupt_a_n,
    output logic o_ext_interrupt_b_n
);
    logic [5:0] pin_direction_reg;
    logic [5:0] output_latch_reg;
    logic [5:0] open_drain_select_reg;
    logic [5:0] pin_meta_reg;
    logic [5:0] pin_sync_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [5:0] readback;
    logic hit_dir;
    logic hit_latch;
    logic hit_odr;
    logic hit_level;

    // low 16 bits only; the bus offers no more
    function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
        hit = (a == base);
    endfunction

    // address decode
    always_comb begin
        hit_dir = 1'b0;
        hit_latch = 1'b0;
        hit_odr = 1'b0;
        hit_level = 1'b0;
        if (hit(i_req.addr, PIN_DIRECTION_ADDR)) begin
            hit_dir = 1'b1;
        end else if (hit(i_req.addr, OUTPUT_LATCH_ADDR)) begin
            hit_latch = 1'b1;
        end else if (hit(i_req.addr, OPEN_DRAIN_SELECT_ADDR)) begin
            hit_odr = 1'b1;
        end else if (hit(i_req.addr, PIN_LEVEL_READBACK_ADDR)) begin
            hit_level = 1'b1;
        end
    end

    // direction; software standby has no effect, so values hold
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_direction_reg <= PIN_DIRECTION_RESET;
        end else if (i_hw_standby) begin
            pin_direction_reg <= PIN_DIRECTION_RESET;
        end else if (i_req.wr && hit_dir) begin
            pin_direction_reg <= i_req.wdata[5:0];
        end
    end

    // output latch; bits 7 and 6 are not stored
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            output_latch_reg <= OUTPUT_LATCH_RESET;
        end else if (i_hw_standby) begin
            output_latch_reg <= OUTPUT_LATCH_RESET;
        end else if (i_req.wr && hit_latch) begin
            output_latch_reg <= i_req.wdata[5:0];
        end
    end

    // open-drain select
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            open_drain_select_reg <= OPEN_DRAIN_SELECT_RESET;
        end else if (i_hw_standby) begin
            open_drain_select_reg <= OPEN_DRAIN_SELECT_RESET;
        end else if (i_req.wr && hit_odr) begin
            open_drain_select_reg <= i_req.wdata[5:0];
        end
    end

    // two-stage synchroniser on the pin levels
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_meta_reg <= 6'h00;
            pin_sync_reg <= 6'h00;
        end else begin
            pin_meta_reg <= i_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // outputs show the latch, inputs the synced level
    assign readback = (pin_direction_reg & output_latch_reg)
        | (~pin_direction_reg & pin_sync_reg);

    // read mux; direction reads give a fixed filler instead of contents
    always_comb begin
        rdata_next = 8'h00;
        if (i_req.rd) begin
            if (hit_dir) begin
                rdata_next = UNDEFINED_READ;
            end else if (hit_latch) begin
                rdata_next = {RESERVED_READ, output_latch_reg};
            end else if (hit_odr) begin
                rdata_next = {RESERVED_READ, open_drain_select_reg};
            end else if (hit_level) begin
                rdata_next = {RESERVED_READ, readback};
            end
        end
    end

    // read data held for exactly the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;

    // pin selection does not depend on any operating mode input
    io_pad_driver #(
        .WIDTH(PORT_WIDTH)
    ) u_pad (
        .i_dir(pin_direction_reg),
        .i_latch(output_latch_reg),
        .i_odr(open_drain_select_reg),
        .i_take(i_periph.take),
        .i_p_oe(i_periph.oe),
        .i_p_out(i_periph.out),
        .o_out(o_pin_out),
        .o_oe(o_pin_oe)
    );

    // synced levels for serial receivers and interrupt inputs
    assign o_pin_level = pin_sync_reg;
    assign o_ext_interrupt_a_n = pin_sync_reg[IRQ_A_PIN];
    assign o_ext_interrupt_b_n = pin_sync_reg[IRQ_B_PIN];
endmodule

// [test/io_port_chk.sv]
/* port checker for io_port, bound below.
 assumes io_port_pkg; shadow copies follow the control registers. */
`timescale 1ns/10ps
module io_port_chk
    import io_port_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hw_standby,
    input wire io_port_pkg::reg_req_type i_req,
    input wire logic [7:0] o_rdata,
    input wire io_port_pkg::periph_ctl_type i_periph,
    input wire logic [5:0] o_pin_out,
    input wire logic [5:0] o_pin_oe,
    input wire logic [5:0] o_pin_level,
    input wire logic o_ext_interrupt_a_n,
    input wire logic o_ext_interrupt_b_n
);
    logic [5:0] dir_reg, lat_reg, odr_reg, val, rb;
    // shadows; standby clears them like reset does
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst || i_hw_standby) begin
            {dir_reg, lat_reg, odr_reg} <= '0;
        end else if (i_req.wr) begin
            if (i_req.addr == PIN_DIRECTION_ADDR) dir_reg <= i_req.wdata[5:0];
            if (i_req.addr == OUTPUT_LATCH_ADDR) lat_reg <= i_req.wdata[5:0];
            if (i_req.addr == OPEN_DRAIN_SELECT_ADDR) odr_reg <= i_req.wdata[5:0];
        end
    end
    // serial takeover wins over the latch
    assign val = i_periph.take & i_periph.out | ~i_periph.take & lat_reg;
    assign rb = dir_reg & lat_reg | ~dir_reg & o_pin_level;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    idle_rd_a: assert property (!$past(i_req.rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
    unmapped_rd_a: assert property (i_req.rd && !(i_req.addr inside {16'hFF52, 16'hFF62,
        16'hFF76}) |=> o_rdata == UNDEFINED_READ) else $error("bad unmapped read");
    latch_rd_a: assert property (i_req.rd && i_req.addr == OUTPUT_LATCH_ADDR
        |=> o_rdata == {RESERVED_READ, $past(lat_reg)}) else $error("bad latch read");
    odr_rd_a: assert property (i_req.rd && i_req.addr == OPEN_DRAIN_SELECT_ADDR
        |=> o_rdata == {RESERVED_READ, $past(odr_reg)}) else $error("bad odr read");
    readback_a: assert property (i_req.rd && i_req.addr == PIN_LEVEL_READBACK_ADDR
        |=> o_rdata == {RESERVED_READ, $past(rb)}) else $error("bad readback");
    drive_en_a: assert property (o_pin_oe == ((i_periph.take & i_periph.oe
        | ~i_periph.take & dir_reg) & ~(odr_reg & val))) else $error("bad enable");
    drive_val_a: assert property (o_pin_out == (val & ~odr_reg))
        else $error("bad drive value");
    irq_level_a: assert property ({o_ext_interrupt_b_n, o_ext_interrupt_a_n} == o_pin_level[5:4])
        else $error("bad interrupt level");
    cover property (i_hw_standby && i_req.wr);
    cover property (i_req.rd && i_req.addr == PIN_LEVEL_READBACK_ADDR);
    cover property (|(i_periph.take & o_pin_oe));
endmodule
bind io_port io_port_chk i_chk (.i_clk, .i_rst, .i_hw_standby, .i_req, .o_rdata, .i_periph,
    .o_pin_out, .o_pin_oe, .o_pin_level, .o_ext_interrupt_a_n, .o_ext_interrupt_b_n);

// [test/pin_partner.sv]
/* far side of the pins: outside drivers plus a pull-up.
 assumes outside drivers yield wherever the port drives. */
`timescale 1ns/10ps
module pin_partner (
    input wire logic [5:0] i_out,
    input wire logic [5:0] i_oe,
    input wire logic [5:0] i_ext_en,
    input wire logic [5:0] i_ext_val,
    output logic [5:0] o_level
);
    // released lines float up, so open-drain highs read 1
    assign o_level = i_oe & i_out | ~i_oe & (~i_ext_en | i_ext_val);
endmodule

// [test/tb_top.sv]
/* self-checking bench for io_port.
 assumes io_port_pkg, pin_partner and a 25 MHz clock. */
`timescale 1ns/10ps
module tb_top;
    import io_port_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_hw_standby = 1'b0;
    reg_req_type i_req = '0;
    periph_ctl_type i_periph = '0;
    logic [5:0] ext_en = '0, ext_val = '0, pin, pin_out, pin_oe, level, dir, lat, odr, v, oe, lv;
    logic [7:0] rdata;
    logic irq_a_n, irq_b_n, rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    int fails = 0, n_tests = 0, cycles = 0;
    io_port i_dut (.i_clk, .i_rst, .i_hw_standby, .i_req, .o_rdata(rdata), .i_periph,
        .i_pin(pin), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_level(level),
        .o_ext_interrupt_a_n(irq_a_n), .o_ext_interrupt_b_n(irq_b_n));
    pin_partner i_far (.i_out(pin_out), .i_oe(pin_oe), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .o_level(pin));
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    task automatic summarize();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", what, e, g);
        end
    endtask
    // one strobe per cycle, back to back
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        i_req <= '{a, d, w, !w};
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    // expected drive and settled pin level from our own copies
    task automatic pins();
        v = i_periph.take & i_periph.out | ~i_periph.take & lat;
        oe = (i_periph.take & i_periph.oe | ~i_periph.take & dir) & ~(odr & v);
        check("oe", {2'h0, oe}, {2'h0, pin_oe});
        check("out", {2'h0, v & ~odr}, {2'h0, pin_out});
        lv = oe & v & ~odr | ~oe & (~ext_en | ext_val);
        check("level", {2'h0, lv}, {2'h0, level});
        check("irq", {6'h00, lv[5:4]}, {6'h00, irq_b_n, irq_a_n});
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge i_clk) begin
        if (rd_seen) check("rdata", exp_q.pop_front(), rdata);
        rd_seen <= i_req.rd;
        cycles++;
        if (cycles > 3000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'h3891));
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd(OUTPUT_LATCH_ADDR, 8'h00);
        rd(OPEN_DRAIN_SELECT_ADDR, 8'h00);
        for (int k = 0; k < 40; k++) begin
            {dir, lat, odr} = 18'($urandom);
            bus(1'b1, PIN_DIRECTION_ADDR, {2'b11, dir});
            bus(1'b1, OUTPUT_LATCH_ADDR, {2'b11, lat});
            bus(1'b1, OPEN_DRAIN_SELECT_ADDR, {2'b11, odr});
            bus(1'b1, {1'b0, 15'($urandom)}, 8'hFF);
            i_periph <= (k % 4 == 0) ? 18'($urandom) : '0;
            {ext_en, ext_val} <= 12'($urandom);
            rd(OUTPUT_LATCH_ADDR, {2'h0, lat});
            rd(OPEN_DRAIN_SELECT_ADDR, {2'h0, odr});
            rd(PIN_DIRECTION_ADDR, UNDEFINED_READ);
            rd({1'b0, 15'($urandom)}, 8'h00);
            pins();
            rd(PIN_LEVEL_READBACK_ADDR, {2'h0, dir & lat | ~dir & level});
        end
        i_hw_standby <= 1'b1;
        bus(1'b1, OUTPUT_LATCH_ADDR, 8'h3F);
        i_hw_standby <= 1'b0;
        i_periph <= '0;
        {dir, lat, odr} = '0;
        rd(OUTPUT_LATCH_ADDR, 8'h00);
        rd(OPEN_DRAIN_SELECT_ADDR, 8'h00);
        i_req <= '0;
        repeat (3) @(posedge i_clk);
        pins();
        summarize();
    end
endmodule
